// ===== rtl/sector_guard_pkg.sv
package sector_guard_pkg;
  // ==========================================================
  // Link commands
  localparam logic [23:0] OPC_PREFIX = 24'h3D2A7F;
  localparam logic [7:0] OPC_ENABLE = 8'hA9;
  localparam logic [7:0] OPC_DISABLE = 8'h9A;
  localparam logic [7:0] OPC_ERASE = 8'hCF;
  localparam int FRAME_BITS = 32;
  localparam int BITCNT_W = 6;
  // ==========================================================
  // Guard map layout
  localparam int SECTORS = 32;
  localparam int SECT_W = 5;
  localparam int PAGE_W = 10;
  localparam logic [7:0] MAP_RESET = 8'h00;
  localparam logic [7:0] MAP_ERASED = 8'hFF;
  localparam int LOW_PART_MSB = 7;
  localparam int LOW_PART_LSB = 6;
  localparam int HIGH_PART_MSB = 5;
  localparam int HIGH_PART_LSB = 4;
  localparam logic [1:0] PART_GUARDED = 2'h3;
  localparam logic [PAGE_W-1:0] LOW_PART_PAGES = 10'h008;
  // ==========================================================
  // Timing at the 200 MHz system clock
  localparam int CLK_MHZ = 200;
  localparam int PIN_GUARD_ENABLE_DELAY_NS = 1000;
  localparam int PIN_GUARD_DISABLE_DELAY_NS = 1000;
  localparam int GUARD_MAP_ERASE_TIME_US = 20;
  localparam int SYNC_STAGES = 2;
  localparam int ENABLE_DELAY_CYC = PIN_GUARD_ENABLE_DELAY_NS * CLK_MHZ / 1000;
  localparam int DISABLE_DELAY_CYC =
    PIN_GUARD_DISABLE_DELAY_NS * CLK_MHZ / 1000;
  localparam int PIN_FILTER_CYC =
    ((ENABLE_DELAY_CYC < DISABLE_DELAY_CYC) ?
     ENABLE_DELAY_CYC : DISABLE_DELAY_CYC) - SYNC_STAGES - 2;
  localparam int ERASE_CYC = GUARD_MAP_ERASE_TIME_US * CLK_MHZ;
  localparam int SCK_HALF_CYC = 10;
  // Idle pin levels {wp_n, mosi, cs_n, sck}
  localparam logic [3:0] PINS_IDLE = 4'hA;
  // ==========================================================
  // Host register map (APB)
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] WP_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam int CTRL_OPC_LSB = 0;
  localparam int CTRL_LEN_LSB = 8;
  localparam logic [7:0] CTRL_OPC_RESET = 8'h00;
  localparam logic [5:0] CTRL_LEN_RESET = 6'h20;
endpackage

// ===== rtl/guard_link_if.sv
`timescale 1ns/1ps
interface guard_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic wp_n_out;
  logic wp_n_oe;
  logic wp_n;
  // ==========================================================
  // Pin resolution
  // Undriven pin floats high through the internal pull-up
  assign wp_n = wp_n_oe ? wp_n_out : 1'b1;
  modport host (
    output sck,
    output cs_n,
    output mosi,
    output wp_n_out,
    output wp_n_oe
  );
  modport device (
    input sck,
    input cs_n,
    input mosi,
    input wp_n
  );
endinterface

// ===== rtl/guard_host.sv
`timescale 1ns/1ps
module guard_host
  import sector_guard_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_CYC
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  guard_link_if.host link
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_LOW = 3'b001,
    S_HIGH = 3'b010,
    S_TAIL = 3'b011,
    S_GAP = 3'b100
  } spi_e;
  spi_e state_q;
  logic [7:0] opc_q;
  logic [5:0] len_q;
  logic wp_hold_q;
  logic [31:0] shift_q;
  logic [5:0] left_q;
  logic [15:0] div_q;
  logic tick;
  logic access;
  logic go;
  logic known;

  // ==========================================================
  // APB slave, no wait states
  assign access = psel_i && penable_i && pready_o;
  assign known = paddr_i == CTRL_OFS || paddr_i == WP_OFS ||
                 paddr_i == STAT_OFS;
  // Start refused while a frame is still on the link
  // Follows the setup-cycle verdict, so start and slave error agree
  assign go = access && pwrite_i && paddr_i == CTRL_OFS && !pslverr_o;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      pready_o <= 1'b1;
      pslverr_o <= !known ||
                   (pwrite_i && paddr_i == CTRL_OFS && state_q != S_IDLE);
      case (paddr_i)
        CTRL_OFS: prdata_o <= {18'h0, len_q, opc_q};
        WP_OFS: prdata_o <= {31'h0, wp_hold_q};
        STAT_OFS: prdata_o <= {31'h0, state_q != S_IDLE};
        default: prdata_o <= 32'h0000_0000;
      endcase
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      opc_q <= CTRL_OPC_RESET;
      len_q <= CTRL_LEN_RESET;
      wp_hold_q <= 1'b0;
    end else if (access && pwrite_i) begin
      if (go) begin
        opc_q <= pwdata_i[CTRL_OPC_LSB +: 8];
        len_q <= pwdata_i[CTRL_LEN_LSB +: 6];
      end
      if (paddr_i == WP_OFS) begin
        wp_hold_q <= pwdata_i[0];
      end
    end
  end

  // ==========================================================
  // Serial engine, mode 0, clock made by divider
  assign tick = div_q == 16'(SCK_HALF - 1);

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q <= 16'h0000;
    end else if (state_q == S_IDLE || tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= S_IDLE;
      link.sck <= 1'b0;
      link.cs_n <= 1'b1;
      link.mosi <= 1'b0;
      shift_q <= 32'h0000_0000;
      left_q <= 6'h00;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (go) begin
            link.cs_n <= 1'b0;
            // Prefix then opcode, most significant bit first
            shift_q <= {OPC_PREFIX, pwdata_i[CTRL_OPC_LSB +: 8]};
            link.mosi <= OPC_PREFIX[23];
            left_q <= pwdata_i[CTRL_LEN_LSB +: 6];
            state_q <= (pwdata_i[CTRL_LEN_LSB +: 6] == 6'h00) ?
                       S_TAIL : S_LOW;
          end
        end
        S_LOW: begin
          if (tick) begin
            link.sck <= 1'b1;
            left_q <= left_q - 6'h01;
            state_q <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (tick) begin
            link.sck <= 1'b0;
            if (left_q == 6'h00) begin
              state_q <= S_TAIL;
            end else begin
              shift_q <= {shift_q[30:0], 1'b0};
              link.mosi <= shift_q[30];
              state_q <= S_LOW;
            end
          end
        end
        S_TAIL: begin
          if (tick) begin
            // Select released only after the last bit
            link.cs_n <= 1'b1;
            state_q <= S_GAP;
          end
        end
        S_GAP: begin
          if (tick) begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Write-protect pin: driven low or released to pull-up
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link.wp_n_out <= 1'b1;
      link.wp_n_oe <= 1'b0;
    end else begin
      link.wp_n_out <= 1'b0;
      link.wp_n_oe <= wp_hold_q;
    end
  end
endmodule

// ===== rtl/guard_device.sv
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module guard_device
  import sector_guard_pkg::*;
#(
  parameter int FILTER_CYCLES = PIN_FILTER_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  guard_link_if.device link,
  input wire logic req_valid_i,
  input wire logic req_map_i,
  input wire logic [SECT_W-1:0] req_sector_i,
  input wire logic [PAGE_W-1:0] req_page_i,
  output logic ans_valid_o,
  output logic ans_allow_o,
  input wire logic map_wr_i,
  input wire logic [SECT_W-1:0] map_idx_i,
  input wire logic [7:0] map_data_i,
  output logic map_wr_ack_o,
  output logic map_wr_nack_o,
  input wire logic [SECT_W-1:0] map_rd_idx_i,
  output logic [7:0] map_rd_data_o,
  output logic busy_o,
  output logic guard_on_o,
  output logic sw_guard_o,
  output logic pin_guard_o
);
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic sck_prev_q;
  logic cs_prev_q;
  logic [31:0] shift_q;
  logic [BITCNT_W-1:0] bits_q;
  logic sck_rise;
  logic cs_rise;
  logic frame_ok;
  logic do_enable;
  logic do_disable;
  logic do_erase;
  logic [15:0] filt_cnt_q;
  logic wp_raw;
  logic [31:0] erase_cnt_q;
  logic [7:0] map_q [SECTORS];
  logic wr_ok;

  // ==========================================================
  // Pin synchronisers {wp_n, mosi, cs_n, sck}
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= PINS_IDLE;
      sync_q <= PINS_IDLE;
    end else begin
      meta_q <= {link.wp_n, link.mosi, link.cs_n, link.sck};
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sync_q[0];
      cs_prev_q <= sync_q[1];
    end
  end

  assign sck_rise = sync_q[0] && !sck_prev_q && !sync_q[1];
  assign cs_rise = sync_q[1] && !cs_prev_q;

  // ==========================================================
  // Frame capture; bit count saturates so long frames fail too
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shift_q <= 32'h0000_0000;
      bits_q <= '0;
    end else if (sync_q[1]) begin
      bits_q <= '0;
    end else if (sck_rise) begin
      shift_q <= {shift_q[30:0], sync_q[2]};
      if (bits_q != '1) begin
        bits_q <= bits_q + 1'b1;
      end
    end
  end

  // Action only at select release with exactly 32 matching bits
  assign frame_ok = cs_rise && bits_q == BITCNT_W'(FRAME_BITS) &&
                    shift_q[31:8] == OPC_PREFIX;
  assign do_enable = frame_ok && shift_q[7:0] == OPC_ENABLE;
  assign do_disable = frame_ok && shift_q[7:0] == OPC_DISABLE;
  assign do_erase = frame_ok && shift_q[7:0] == OPC_ERASE;

  // ==========================================================
  // Write-protect noise filter
  assign wp_raw = !sync_q[3];

  // Level must hold FILTER_CYCLES before it is believed
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_guard_o <= 1'b0;
      filt_cnt_q <= 16'h0000;
    end else if (wp_raw == pin_guard_o) begin
      filt_cnt_q <= 16'h0000;
    end else if (filt_cnt_q == 16'(FILTER_CYCLES - 1)) begin
      pin_guard_o <= wp_raw;
      filt_cnt_q <= 16'h0000;
    end else begin
      filt_cnt_q <= filt_cnt_q + 16'h0001;
    end
  end

  // ==========================================================
  // Command protection state; volatile, cleared by reset
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sw_guard_o <= 1'b0;
    end else if (do_enable) begin
      sw_guard_o <= 1'b1;
    end else if (do_disable && !pin_guard_o) begin
      sw_guard_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      guard_on_o <= 1'b0;
    end else begin
      guard_on_o <= sw_guard_o || pin_guard_o;
    end
  end

  // ==========================================================
  // Self-timed map erase
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_o <= 1'b0;
      erase_cnt_q <= 32'h0000_0000;
    end else if (busy_o) begin
      if (erase_cnt_q == 32'h0000_0000) begin
        busy_o <= 1'b0;
      end else begin
        erase_cnt_q <= erase_cnt_q - 32'h0000_0001;
      end
    end else if (do_erase && !pin_guard_o) begin
      // Command state not consulted here
      busy_o <= 1'b1;
      erase_cnt_q <= 32'(ERASE_CYCLES - 1);
    end
  end

  // ==========================================================
  // Guard map; reset stands in for the delivered contents
  // Programming only clears bits, so raising one needs an erase
  assign wr_ok = map_wr_i && !busy_o && !pin_guard_o;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < SECTORS; i++) begin
        map_q[i] <= MAP_RESET;
      end
    end else if (busy_o && erase_cnt_q == 32'h0000_0000) begin
      for (int i = 0; i < SECTORS; i++) begin
        map_q[i] <= MAP_ERASED;
      end
    end else if (wr_ok) begin
      map_q[map_idx_i] <= map_q[map_idx_i] & map_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      map_wr_ack_o <= 1'b0;
      map_wr_nack_o <= 1'b0;
      map_rd_data_o <= MAP_RESET;
    end else begin
      map_wr_ack_o <= wr_ok;
      map_wr_nack_o <= map_wr_i && !wr_ok;
      map_rd_data_o <= map_q[map_rd_idx_i];
    end
  end

  // ==========================================================
  // Access check for program and erase requests
  function automatic logic sector_marked(input logic [SECT_W-1:0] s,
                                         input logic [PAGE_W-1:0] p);
    logic [7:0] b;
    b = map_q[s];
    if (s != '0) begin
      sector_marked = b == MAP_ERASED;
    end else if (p < LOW_PART_PAGES) begin
      sector_marked = b[LOW_PART_MSB:LOW_PART_LSB] == PART_GUARDED;
    end else begin
      sector_marked = b[HIGH_PART_MSB:HIGH_PART_LSB] == PART_GUARDED;
    end
  endfunction

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ans_valid_o <= 1'b0;
      ans_allow_o <= 1'b0;
    end else begin
      ans_valid_o <= req_valid_i;
      if (!req_valid_i) begin
        ans_allow_o <= 1'b0;
      end else if (req_map_i) begin
        ans_allow_o <= !pin_guard_o && !busy_o;
      end else begin
        ans_allow_o <= !((sw_guard_o || pin_guard_o) &&
                         sector_marked(req_sector_i, req_page_i));
      end
    end
  end
endmodule

// ===== dv/guard_link_assertions.sv
`timescale 1ns/1ps
module guard_link_assertions #(
  parameter int SCK_HALF = 3
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic wp_n_out,
  input wire logic wp_n_oe,
  input wire logic wp_n
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // ====================================
  // Length of each high half of the clock
  logic [7:0] hi_q;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hi_q <= 8'h00;
    end else begin
      hi_q <= sck ? hi_q + 8'h01 : 8'h00;
    end
  end
  sequence quiet_start;
    (!sck && !cs_n) [*2];
  endsequence
  sequence idle_gap;
    cs_n [*3];
  endsequence
  // ====================================
  // Checks
  pullup_level_a: assert property (!wp_n_oe |-> wp_n)
    else $error("wp pin not pulled high");
  wp_drive_a: assert property (wp_n_oe |-> !wp_n_out)
    else $error("wp pin driven high");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("clock moves outside frame");
  mosi_hold_a: assert property (sck |-> $stable(mosi))
    else $error("data moved while clock high");
  high_len_a: assert property ($fell(sck) |-> hi_q == SCK_HALF)
    else $error("clock high length wrong");
  frame_start_a: assert property ($fell(cs_n) |-> quiet_start)
    else $error("clock too early after select");
  select_gap_a: assert property ($rose(cs_n) |-> idle_gap)
    else $error("select gap too short");
  fall_inside_a: assert property ($fell(sck) |-> !cs_n)
    else $error("select released before last bit");
endmodule

// ===== dv/sector_write_protection_tb_top.sv
`timescale 1ns/1ps
module sector_write_protection_tb_top;
  import sector_guard_pkg::*;
  // Short counts keep the run brief
  localparam int FILT = 6;
  localparam int ERAS = 20;
  localparam int HALF = 3;
  logic sys_clk, resetn, psel, penable, pwrite, rv, rm, mw;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, av, aa, ack, nack, busy, gon, swg, ping;
  logic [4:0] rs, mi, ri;
  logic [9:0] rp;
  logic [7:0] md, mrd;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  guard_link_if guard_link_if_i();
  guard_host #(.SCK_HALF(HALF)) guard_host_i (.sys_clk_i(sys_clk),
    .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .link(guard_link_if_i));
  guard_device #(.FILTER_CYCLES(FILT), .ERASE_CYCLES(ERAS))
    guard_device_i (.sys_clk_i(sys_clk), .resetn_i(resetn),
    .link(guard_link_if_i), .req_valid_i(rv), .req_map_i(rm),
    .req_sector_i(rs), .req_page_i(rp), .ans_valid_o(av),
    .ans_allow_o(aa), .map_wr_i(mw), .map_idx_i(mi), .map_data_i(md),
    .map_wr_ack_o(ack), .map_wr_nack_o(nack), .map_rd_idx_i(ri),
    .map_rd_data_o(mrd), .busy_o(busy), .guard_on_o(gon),
    .sw_guard_o(swg), .pin_guard_o(ping));
  guard_link_assertions #(.SCK_HALF(HALF)) guard_link_assertions_i (
    .sys_clk_i(sys_clk), .resetn_i(resetn),
    .sck(guard_link_if_i.sck), .cs_n(guard_link_if_i.cs_n),
    .mosi(guard_link_if_i.mosi), .wp_n_out(guard_link_if_i.wp_n_out),
    .wp_n_oe(guard_link_if_i.wp_n_oe), .wp_n(guard_link_if_i.wp_n));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ====================================
  // Shared tasks
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic finish_frame();
    do begin
      apb(1'b0, STAT_OFS, 32'h0);
    end while (rd[0] !== 1'b0);
    tick(8);
  endtask
  task automatic frame(input logic [7:0] op, input logic [5:0] len);
    apb(1'b1, CTRL_OFS, {18'h0, len, op});
    finish_frame();
  endtask
  task automatic setwp(input logic v);
    apb(1'b1, WP_OFS, {31'h0, v});
    // Two sync stages, filter, then the registered combined flag
    tick(FILT + 6);
  endtask
  task automatic fl(input logic [2:0] e);
    chk({29'h0, swg, ping, gon}, {29'h0, e});
  endtask
  task automatic rq(input logic m, input logic [4:0] s,
                    input logic [9:0] p, input logic e);
    @(posedge sys_clk);
    rv <= 1'b1;
    rm <= m;
    rs <= s;
    rp <= p;
    @(posedge sys_clk);
    rv <= 1'b0;
    #1 chk({30'h0, av, aa}, {30'h0, 1'b1, e});
  endtask
  task automatic mwr(input logic [4:0] i, input logic [7:0] d,
                     input logic e);
    @(posedge sys_clk);
    mw <= 1'b1;
    mi <= i;
    md <= d;
    @(posedge sys_clk);
    mw <= 1'b0;
    #1 chk({30'h0, ack, nack}, {30'h0, e, ~e});
  endtask
  task automatic mrd_chk(input logic [4:0] i, input logic [7:0] e);
    @(posedge sys_clk);
    ri <= i;
    @(posedge sys_clk);
    #1 chk({24'h0, mrd}, {24'h0, e});
  endtask
  task automatic erase_run();
    int n;
    n = 0;
    frame(OPC_ERASE, 6'h20);
    chk({31'h0, busy}, 32'h1);
    while (busy !== 1'b0 && n < ERAS) begin
      tick(1);
      n++;
    end
    chk({31'h0, busy}, 32'h0);
    for (int i = 0; i < SECTORS; i++) mrd_chk(5'(i), MAP_ERASED);
  endtask
  // ====================================
  // Scenarios
  task automatic t_reset();
    fl(3'h0);
    for (int i = 0; i < SECTORS; i++) mrd_chk(5'(i), MAP_RESET);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, STAT_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, {18'h0, CTRL_LEN_RESET, CTRL_OPC_RESET});
  endtask
  task automatic t_commands();
    frame(OPC_ENABLE, 6'h20);
    fl(3'h5);
    frame(OPC_DISABLE, 6'h1F);
    fl(3'h5);
    frame(8'h55, 6'h20);
    fl(3'h5);
    apb(1'b1, CTRL_OFS, {18'h0, 6'h20, OPC_DISABLE});
    apb(1'b1, CTRL_OFS, {18'h0, 6'h20, OPC_ENABLE});
    chk({31'h0, err}, 32'h1);
    tick(150);
    fl(3'h5);
    finish_frame();
    fl(3'h0);
  endtask
  task automatic t_map();
    erase_run();
    rq(1'b0, 5'h05, 10'h000, 1'b1);
    mwr(5'h00, 8'hCF, 1'b1);
    mwr(5'h03, 8'h00, 1'b1);
    mwr(5'h03, 8'hFF, 1'b1);
    mrd_chk(5'h00, 8'hCF);
    mrd_chk(5'h03, 8'h00);
    frame(OPC_ENABLE, 6'h20);
    rq(1'b0, 5'h00, 10'h007, 1'b0);
    rq(1'b0, 5'h00, 10'h008, 1'b1);
    rq(1'b0, 5'h03, 10'h000, 1'b1);
    rq(1'b0, 5'h05, 10'h000, 1'b0);
    rq(1'b1, 5'h00, 10'h000, 1'b1);
    erase_run();
    frame(OPC_DISABLE, 6'h20);
  endtask
  task automatic t_pin();
    frame(OPC_ENABLE, 6'h20);
    setwp(1'b1);
    fl(3'h7);
    rq(1'b0, 5'h05, 10'h000, 1'b0);
    rq(1'b1, 5'h00, 10'h000, 1'b0);
    mwr(5'h03, 8'h00, 1'b0);
    frame(OPC_DISABLE, 6'h20);
    fl(3'h7);
    frame(OPC_ERASE, 6'h20);
    chk({31'h0, busy}, 32'h0);
    setwp(1'b0);
    fl(3'h5);
    frame(OPC_DISABLE, 6'h20);
    fl(3'h0);
    setwp(1'b1);
    fl(3'h3);
    setwp(1'b0);
    fl(3'h0);
    apb(1'b1, WP_OFS, 32'h1);
    apb(1'b1, WP_OFS, 32'h0);
    tick(FILT + 4);
    fl(3'h0);
  endtask
  // ====================================
  // Run control
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    {psel, penable, pwrite, rv, rm, mw} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    {rs, mi, ri, rp, md} = 33'h0;
    resetn = 1'b0;
    tick(10);
    resetn <= 1'b1;
    tick(2);
    t_reset();
    t_commands();
    t_map();
    t_pin();
    close_out();
  end
endmodule
